// ### hw/ssf_status_flags.sv
// Primary and secondary status bytes with in-band interrupt sources.
// Assumes events and modes come from logic on MCLK_I; read pins do not.
`default_nettype none

module ssf_status_flags
  import ssf_pkg::*;
#(
  parameter int unsigned BURST_SAMPLES = SSF_BURST_SAMPLES
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic SCL_I,
  input wire logic RD_EN_I,
  input wire logic [7:0] RD_ADDR_I,
  input wire ssf_evt_s EVENTS_I,
  input wire ssf_mode_s MODE_I,
  output logic [7:0] RD_DATA_O,
  output logic RD_VALID_O,
  output logic IBI_REQ_O,
  output logic [7:0] PRIMARY_O,
  output logic [7:0] SECONDARY_O,
  output logic BURST_LIMIT_O
);

  localparam logic [7:0] BURST_BYTES =
    8'(BURST_SAMPLES * SSF_SAMPLE_BYTES);

  // Flag update: a set in the same cycle wins over a clear
  function automatic logic flag_upd(input logic cur, input logic set,
                                    input logic clr);
    logic r;
    r = cur;
    if (set) begin
      r = 1'b1;
    end else if (clr) begin
      r = 1'b0;
    end
    return r;
  endfunction : flag_upd

  // Pin synchronisers
  logic scl_s1_reg;
  logic scl_s2_reg;
  logic scl_d_reg;
  logic rden_s1_reg;
  logic rden_s2_reg;
  logic [7:0] addr_s1_reg;
  logic [7:0] addr_s2_reg;

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      rden_s1_reg <= 1'b0;
      rden_s2_reg <= 1'b0;
      addr_s1_reg <= 8'h00;
      addr_s2_reg <= 8'h00;
    end else begin
      scl_s1_reg <= SCL_I;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      rden_s1_reg <= RD_EN_I;
      rden_s2_reg <= rden_s1_reg;
      addr_s1_reg <= RD_ADDR_I;
      addr_s2_reg <= addr_s1_reg;
    end
  end

  logic rd_take;
  assign rd_take = scl_s2_reg & ~scl_d_reg & rden_s2_reg;

  // Read sequencer
  ssf_rd_e rd_state_reg;
  ssf_rd_e rd_state_next;
  logic [7:0] rd_addr_reg;

  always_comb begin
    case (rd_state_reg)
      SSF_RD_IDLE: begin
        rd_state_next = rd_take ? SSF_RD_RESP : SSF_RD_IDLE;
      end
      SSF_RD_RESP: begin
        rd_state_next = SSF_RD_IDLE;
      end
      default: begin
        rd_state_next = SSF_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      rd_state_reg <= SSF_RD_IDLE;
    end else begin
      rd_state_reg <= rd_state_next;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      rd_addr_reg <= 8'h00;
    end else if (rd_take && rd_state_reg == SSF_RD_IDLE) begin
      rd_addr_reg <= addr_s2_reg;
    end
  end

  logic rd_resp;
  logic rd_prim;
  logic rd_sec;
  assign rd_resp = (rd_state_reg == SSF_RD_RESP);
  assign rd_prim = rd_resp && (rd_addr_reg == SSF_PRIMARY_ADDR);
  assign rd_sec = rd_resp && (rd_addr_reg == SSF_SECONDARY_ADDR);

  // Clear qualifiers
  logic no_hdr;
  logic i2c_mag;
  logic i2c_temp;
  assign no_hdr = ~MODE_I.hdr;
  assign i2c_mag = EVENTS_I.mag_data_acc & ~MODE_I.i3c;
  assign i2c_temp = EVENTS_I.temp_data_acc & ~MODE_I.i3c;

  // Flags
  logic mag_int_reg;
  logic temp_int_reg;
  logic mot_int_reg;
  logic sync_tick_fault_reg;
  logic fuse_done_reg;
  logic mag_rdy_reg;
  logic temp_rdy_reg;
  logic mot_seen_reg;
  logic proto_err_reg;

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      mag_int_reg <= 1'b0;
    end else begin
      mag_int_reg <= flag_upd(mag_int_reg, EVENTS_I.mag_done,
        no_hdr & (EVENTS_I.take_meas | i2c_mag |
        EVENTS_I.ibi_sent | rd_prim));
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      temp_int_reg <= 1'b0;
    end else begin
      temp_int_reg <= flag_upd(temp_int_reg, EVENTS_I.temp_done,
        no_hdr & (EVENTS_I.take_meas | i2c_temp |
        EVENTS_I.ibi_sent | rd_prim));
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      mot_int_reg <= 1'b0;
    end else begin
      mot_int_reg <= flag_upd(mot_int_reg, EVENTS_I.motion,
        EVENTS_I.start_mdt | EVENTS_I.ibi_sent | rd_prim);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      sync_tick_fault_reg <= 1'b0;
    end else begin
      sync_tick_fault_reg <= flag_upd(sync_tick_fault_reg,
        EVENTS_I.sync_tick_parity_err, EVENTS_I.ibi_sent);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      fuse_done_reg <= 1'b0;
    end else begin
      fuse_done_reg <= flag_upd(fuse_done_reg, EVENTS_I.fuse_done,
        no_hdr & EVENTS_I.fuse_reload);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      mag_rdy_reg <= 1'b0;
    end else begin
      mag_rdy_reg <= flag_upd(mag_rdy_reg, EVENTS_I.mag_done,
        no_hdr & EVENTS_I.mag_data_acc);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      temp_rdy_reg <= 1'b0;
    end else begin
      temp_rdy_reg <= flag_upd(temp_rdy_reg, EVENTS_I.temp_done,
        no_hdr & EVENTS_I.temp_data_acc);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      mot_seen_reg <= 1'b0;
    end else begin
      mot_seen_reg <= flag_upd(mot_seen_reg, EVENTS_I.motion,
        EVENTS_I.start_mdt);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      proto_err_reg <= 1'b0;
    end else begin
      proto_err_reg <= flag_upd(proto_err_reg, EVENTS_I.proto_err,
        rd_sec);
    end
  end

  // Pending interrupt code
  logic [1:0] pend_code;
  always_comb begin
    if (proto_err_reg) begin
      pend_code = SSF_PEND_PROTO;
    end else if (mot_int_reg) begin
      pend_code = SSF_PEND_MOTION;
    end else if (mag_int_reg | temp_int_reg) begin
      pend_code = SSF_PEND_READY;
    end else begin
      pend_code = SSF_PEND_NONE;
    end
  end

  // Status byte images
  logic [7:0] primary_next;
  logic [7:0] secondary_next;
  always_comb begin
    primary_next = SSF_PRIMARY_RST;
    primary_next[SSF_P_MAG_INT] = mag_int_reg;
    primary_next[SSF_P_TEMP_INT] = temp_int_reg;
    primary_next[SSF_P_MOT_INT] = mot_int_reg;
    primary_next[SSF_P_SYNC_TICK_FAULT] = sync_tick_fault_reg;
    primary_next[SSF_P_FUSE_DONE] = fuse_done_reg;
    primary_next[SSF_P_SELFTEST] = MODE_I.selftest_fail;
    primary_next[SSF_P_MAG_RDY] = mag_rdy_reg;
    primary_next[SSF_P_TEMP_RDY] = temp_rdy_reg;
  end

  always_comb begin
    secondary_next = SSF_SECONDARY_RST;
    secondary_next[SSF_S_PEND_LSB +: 2] = pend_code;
    secondary_next[SSF_S_MOT_SEEN] = mot_seen_reg;
    secondary_next[SSF_S_PROTO_ERR] = proto_err_reg;
    secondary_next[SSF_S_ACT_LSB +: 2] =
      {MODE_I.meas_active, 1'b0};
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      PRIMARY_O <= SSF_PRIMARY_RST;
      SECONDARY_O <= SSF_SECONDARY_RST;
    end else begin
      PRIMARY_O <= primary_next;
      SECONDARY_O <= secondary_next;
    end
  end

  // Read answer
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      RD_DATA_O <= 8'h00;
      RD_VALID_O <= 1'b0;
    end else begin
      RD_VALID_O <= rd_resp;
      if (rd_prim) begin
        RD_DATA_O <= primary_next;
      end else if (rd_sec) begin
        RD_DATA_O <= secondary_next;
      end else if (rd_resp) begin
        RD_DATA_O <= 8'h00;
      end
    end
  end

  // In-band interrupt request
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      IBI_REQ_O <= 1'b0;
    end else begin
      IBI_REQ_O <= mag_int_reg | temp_int_reg | mot_int_reg |
        sync_tick_fault_reg;
    end
  end

  // Queue burst byte counter
  logic burst_mode;
  logic [7:0] burst_cnt_reg;
  assign burst_mode = MODE_I.fifo_en & MODE_I.loop_en;

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      burst_cnt_reg <= SSF_CNT_RST;
    end else if (EVENTS_I.xfer_start) begin
      burst_cnt_reg <= SSF_CNT_RST;
    end else if (burst_mode && EVENTS_I.fifo_byte_rd &&
                 burst_cnt_reg < BURST_BYTES) begin
      burst_cnt_reg <= burst_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      BURST_LIMIT_O <= 1'b0;
    end else begin
      BURST_LIMIT_O <= burst_mode && !EVENTS_I.xfer_start &&
        (burst_cnt_reg >= BURST_BYTES);
    end
  end

endmodule : ssf_status_flags

`default_nettype wire

// ### include/ssf_pkg.sv
// Constants and carrier types for the sensor status flag logic.
// Assumes one core clock domain; bus pins arrive unsynchronised.
`default_nettype none

package ssf_pkg;

  localparam int unsigned SSF_REG_W = 8;

  // Register byte addresses
  localparam logic [7:0] SSF_PRIMARY_ADDR = 8'h18;
  localparam logic [7:0] SSF_SECONDARY_ADDR = 8'h19;

  // Reset values
  localparam logic [7:0] SSF_PRIMARY_RST = 8'h00;
  localparam logic [7:0] SSF_SECONDARY_RST = 8'h00;

  // Primary status bit positions
  localparam int unsigned SSF_P_MAG_INT = 0;
  localparam int unsigned SSF_P_TEMP_INT = 1;
  localparam int unsigned SSF_P_MOT_INT = 2;
  localparam int unsigned SSF_P_SYNC_TICK_FAULT = 3;
  localparam int unsigned SSF_P_FUSE_DONE = 4;
  localparam int unsigned SSF_P_SELFTEST = 5;
  localparam int unsigned SSF_P_MAG_RDY = 6;
  localparam int unsigned SSF_P_TEMP_RDY = 7;

  // Secondary status bit positions
  localparam int unsigned SSF_S_PEND_LSB = 0;
  localparam int unsigned SSF_S_MOT_SEEN = 2;
  localparam int unsigned SSF_S_PROTO_ERR = 5;
  localparam int unsigned SSF_S_ACT_LSB = 6;

  // Pending interrupt codes
  localparam logic [1:0] SSF_PEND_NONE = 2'h0;
  localparam logic [1:0] SSF_PEND_READY = 2'h1;
  localparam logic [1:0] SSF_PEND_MOTION = 2'h2;
  localparam logic [1:0] SSF_PEND_PROTO = 2'h3;

  // Queue burst limit: samples and bytes per sample
  localparam int unsigned SSF_BURST_SAMPLES = 8;
  localparam int unsigned SSF_SAMPLE_BYTES = 6;
  localparam logic [7:0] SSF_CNT_RST = 8'h00;

  // One-cycle event pulses from core logic
  typedef struct packed {
    logic mag_done;
    logic temp_done;
    logic motion;
    logic sync_tick_parity_err;
    logic fuse_done;
    logic fuse_reload;
    logic take_meas;
    logic start_mdt;
    logic mag_data_acc;
    logic temp_data_acc;
    logic ibi_sent;
    logic proto_err;
    logic fifo_byte_rd;
    logic xfer_start;
  } ssf_evt_s;

  // Levels describing bus and core mode
  typedef struct packed {
    logic hdr;
    logic i3c;
    logic selftest_fail;
    logic meas_active;
    logic fifo_en;
    logic loop_en;
  } ssf_mode_s;

  typedef enum logic [1:0] {
    SSF_RD_IDLE = 2'b01,
    SSF_RD_RESP = 2'b10
  } ssf_rd_e;

endpackage : ssf_pkg

`default_nettype wire

// ### verification/ssf_status_flags_sva.sv
// Port checker for the status flag block.
// Assumes binding into ssf_status_flags on its single core clock.
`default_nettype none
module ssf_status_flags_sva
  import ssf_pkg::*;
#(
  parameter int unsigned BURST_SAMPLES = SSF_BURST_SAMPLES
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic SCL_I,
  input wire logic RD_EN_I,
  input wire logic [7:0] RD_ADDR_I,
  input wire ssf_evt_s EVENTS_I,
  input wire ssf_mode_s MODE_I,
  input wire logic [7:0] RD_DATA_O,
  input wire logic RD_VALID_O,
  input wire logic IBI_REQ_O,
  input wire logic [7:0] PRIMARY_O,
  input wire logic [7:0] SECONDARY_O,
  input wire logic BURST_LIMIT_O
);
  localparam logic [7:0] LIM = 8'(BURST_SAMPLES * SSF_SAMPLE_BYTES);
  logic [7:0] cnt_reg;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  // Burst byte count
  always_ff @(posedge MCLK_I) begin
    if (RESET_I || EVENTS_I.xfer_start) begin
      cnt_reg <= 8'h00;
    end else if (EVENTS_I.fifo_byte_rd && MODE_I.fifo_en && MODE_I.loop_en
                 && cnt_reg < LIM) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  mag_set_a: assert property (
    EVENTS_I.mag_done |-> ##2 PRIMARY_O[0] && PRIMARY_O[6])
    else $error("mag flags not set");
  motion_set_a: assert property (
    EVENTS_I.motion |-> ##2 PRIMARY_O[2] && SECONDARY_O[2])
    else $error("motion flags not set");
  fault_set_a: assert property (
    EVENTS_I.sync_tick_parity_err |-> ##2 PRIMARY_O[3] && IBI_REQ_O)
    else $error("parity fault not raised");
  fault_clr_a: assert property (
    EVENTS_I.ibi_sent && !EVENTS_I.sync_tick_parity_err |->
      ##2 !PRIMARY_O[3])
    else $error("parity fault not cleared");
  selftest_low_a: assert property (
    !MODE_I.selftest_fail [*3] |-> !PRIMARY_O[5])
    else $error("self-test bit high");
  act_low_a: assert property (
    !SECONDARY_O[6] && SECONDARY_O[4:3] == 2'h0)
    else $error("fixed zero bits set");
  hdr_hold_a: assert property (
    MODE_I.hdr ##1 1'b1 |=>
      ((~PRIMARY_O & $past(PRIMARY_O)) & 8'hD3) == 8'h00)
    else $error("flag cleared in hdr");
  pend_code_a: assert property (
    SECONDARY_O[1:0] == (SECONDARY_O[5] ? 2'h3 : PRIMARY_O[2] ? 2'h2 :
                         |PRIMARY_O[1:0] ? 2'h1 : 2'h0))
    else $error("pending code wrong");
  proto_set_a: assert property (
    EVENTS_I.proto_err |-> ##2 SECONDARY_O[5] && SECONDARY_O[1:0] == 2'h3)
    else $error("protocol error not set");
  burst_lim_a: assert property (
    cnt_reg == LIM && MODE_I.fifo_en && MODE_I.loop_en &&
      !EVENTS_I.xfer_start |=> BURST_LIMIT_O)
    else $error("burst limit missing");
endmodule : ssf_status_flags_sva

bind ssf_status_flags ssf_status_flags_sva #(
  .BURST_SAMPLES(BURST_SAMPLES)
) ssf_status_flags_sva_i (
  .MCLK_I(MCLK_I), .RESET_I(RESET_I), .SCL_I(SCL_I), .RD_EN_I(RD_EN_I),
  .RD_ADDR_I(RD_ADDR_I), .EVENTS_I(EVENTS_I), .MODE_I(MODE_I),
  .RD_DATA_O(RD_DATA_O), .RD_VALID_O(RD_VALID_O), .IBI_REQ_O(IBI_REQ_O),
  .PRIMARY_O(PRIMARY_O), .SECONDARY_O(SECONDARY_O),
  .BURST_LIMIT_O(BURST_LIMIT_O)
);
`default_nettype wire

// ### verification/ssf_host_model.sv
// Bus controller model issuing single-byte register reads.
// Assumes the core clock paces its link clock frames.
`default_nettype none
module ssf_host_model (
  input wire logic clk_i,
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  output logic scl_o,
  output logic en_o,
  output logic [7:0] addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b0;
    en_o = 1'b0;
    addr_o = 8'h00;
  end
  // Frame of eight core cycles, link clock high for four
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d,
                           output bit ok);
    ok = 1'b0;
    d = 8'h00;
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_i);
      if (k == 0) begin
        addr_o = a;
        en_o = 1'b1;
      end
      scl_o = (k >= 1 && k < 5);
      if (valid_i === 1'b1 && !ok) begin
        ok = 1'b1;
        d = data_i;
      end
    end
    en_o = 1'b0;
    addr_o = ~a;
  endtask : read_byte
endmodule : ssf_host_model
`default_nettype wire

// ### verification/ssf_status_flags_tb.sv
// Self-checking bench for the status flag block.
// Assumes the host model and the bound checker are compiled alongside.
`default_nettype none
module ssf_status_flags_tb
  import ssf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic scl, rd_en, valid, ibi, burst;
  logic [7:0] addr, data, prim, sec, got;
  ssf_evt_s ev = '0;
  ssf_mode_s mode = '0;
  int fail_count = 0;
  int tests_run = 0;
  bit ok;
  // Mode, event pulse, expected primary, expected secondary
  localparam logic [35:0] ROWS [18] = '{
    36'h02000_41_01, 36'h00080_40_00, 36'h00020_00_00, 36'h01000_82_01,
    36'h00008_80_00, 36'h00010_00_00, 36'h00800_04_06, 36'h02000_45_06,
    36'h00004_45_27, 36'h00040_41_23, 36'h00400_49_23, 36'h00008_40_23,
    36'h00200_50_23, 36'h80120_50_23, 36'h30000_70_A3, 36'h00120_00_23,
    36'h02000_41_23, 36'h40020_01_23};
  always #20 mclk = ~mclk;
  ssf_status_flags #(.BURST_SAMPLES(1)) ssf_status_flags_i (
    .MCLK_I(mclk), .RESET_I(rst), .SCL_I(scl), .RD_EN_I(rd_en),
    .RD_ADDR_I(addr), .EVENTS_I(ev), .MODE_I(mode), .RD_DATA_O(data),
    .RD_VALID_O(valid), .IBI_REQ_O(ibi), .PRIMARY_O(prim),
    .SECONDARY_O(sec), .BURST_LIMIT_O(burst));
  ssf_host_model ssf_host_model_i (.clk_i(mclk), .valid_i(valid),
    .data_i(data), .scl_o(scl), .en_o(rd_en), .addr_o(addr));
  task automatic conclude();
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic pulse(input ssf_evt_s e);
    @(negedge mclk);
    ev = e;
    @(negedge mclk);
    ev = '0;
  endtask : pulse
  task automatic rd(input logic [7:0] a);
    ssf_host_model_i.read_byte(a, got, ok);
    if (!ok) begin
      fail_count++;
      conclude();
    end
    repeat (2) @(negedge mclk);
  endtask : rd
  initial begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    check(prim, SSF_PRIMARY_RST);
    check(sec, SSF_SECONDARY_RST);
    for (int i = 0; i < 18; i++) begin
      mode = ssf_mode_s'(ROWS[i][35:30]);
      pulse(ssf_evt_s'(ROWS[i][29:16]));
      repeat (2) @(negedge mclk);
      check(prim, ROWS[i][15:8]);
      check(sec, ROWS[i][7:0]);
      check({7'h00, ibi}, {7'h00, |ROWS[i][11:8]});
    end
    rd(SSF_PRIMARY_ADDR);
    check(got, 8'h01);
    check(prim, 8'h00);
    rd(SSF_SECONDARY_ADDR);
    check(got, 8'h23);
    check(sec, 8'h00);
    rd(8'h1A);
    check(got, 8'h00);
    // Bus data access and register read clear the interrupt flags
    mode = '0;
    pulse(ssf_evt_s'(14'h1800));
    pulse(ssf_evt_s'(14'h0010));
    repeat (2) @(negedge mclk);
    check(prim, 8'h04);
    rd(SSF_PRIMARY_ADDR);
    check(got, 8'h04);
    check(prim, 8'h00);
    check(sec, 8'h04);
    mode = ssf_mode_s'(6'h03);
    pulse(ssf_evt_s'(14'h0001));
    // Controller stops at one six-byte sample
    for (int i = 1; i <= 6; i++) begin
      pulse(ssf_evt_s'(14'h0002));
      repeat (2) @(negedge mclk);
      check({7'h00, burst}, {7'h00, i == 6});
    end
    pulse(ssf_evt_s'(14'h0001));
    repeat (2) @(negedge mclk);
    check({7'h00, burst}, 8'h00);
    pulse(ssf_evt_s'(14'h2000));
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    check(prim, SSF_PRIMARY_RST);
    rst = 1'b0;
    @(negedge mclk);
    check(prim, SSF_PRIMARY_RST);
    conclude();
  end
endmodule : ssf_status_flags_tb
`default_nettype wire
